// file: inc/spf_pkg.sv
// Package: constants and types for the switch port state filter
package spf_pkg;
    localparam int NUM_PORTS      = 27;
    localparam int VID_W          = 12;
    localparam int NUM_VLANS      = 4095;
    localparam int NUM_RSV        = 16;
    localparam int QUEUE_W        = 3;
    localparam int NUM_AGGR       = 16;
    localparam int AGGR_W         = 4;
    localparam logic [1:0] CMD_IDLE  = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h2;
    // Reserved group address prefix 01-80-C2-00-00-0x, low nibble dropped
    localparam logic [43:0] RSV_PREFIX = 44'h018_0C20_0000;
    localparam logic [3:0]  RSV_AUTH_IDX = 4'h3;
    localparam logic [NUM_PORTS-1:0] MASK_RESET = '0;
    localparam logic [QUEUE_W-1:0]   QUEUE_RESET = '0;

    typedef enum logic [2:0] {
        SPF_IDLE  = 3'b001,
        SPF_WRITE = 3'b010,
        SPF_DONE  = 3'b100
    } spf_cmd_state_t;
endpackage

// file: rtl/spf_vlan_table.sv
// VLAN table store: one entry of flag plus member mask per VLAN
module spf_vlan_table #(
    parameter int NUM_PORTS = 27,
    parameter int VID_W     = 12,
    parameter int NUM_VLANS = 4095
) (
    // Clock
    input  wire logic                 sys_clk_i,
    // Write side
    input  wire logic                 wr_en_i,
    input  wire logic [VID_W-1:0]     wr_idx_i,
    input  wire logic                 wr_chk_i,
    input  wire logic [NUM_PORTS-1:0] wr_members_i,
    // Lookup side, one cycle latency
    input  wire logic [VID_W-1:0]     rd_idx_i,
    output logic                      rd_chk_o,
    output logic [NUM_PORTS-1:0]      rd_members_o
);
    // Flag kept above the member bits; contents are not reset
    logic [NUM_PORTS:0] mem [NUM_VLANS];
    logic [NUM_PORTS:0] rd_word;

    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i && (int'(wr_idx_i) < NUM_VLANS)) begin
            mem[wr_idx_i] <= {wr_chk_i, wr_members_i};
        end
        if (int'(rd_idx_i) < NUM_VLANS) begin
            rd_word <= mem[rd_idx_i];
        end else begin
            rd_word <= '0;
        end
    end

    assign rd_chk_o     = rd_word[NUM_PORTS];
    assign rd_members_o = rd_word[NUM_PORTS-1:0];
endmodule

// file: rtl/spf_filter.sv
// Forwarding filter, learning control and reserved address redirect
// Behaviour
// - Reserved frames reach CPU whatever the port state
// - Entry flag set: non-member ingress frame discarded
// - VLAN table written by command, one entry each
// - Global per-port mask enables ingress check
// - Learn-check suppresses learning of filtered frames
// - Per-port learn enable bit gates learning
// - Flag and member bit encode port state
// - Member bit p governs port p forwarding, learning
// - Forwarding ports learn at line rate
// - Redirect enabled per port per reserved address
// - Per-address field selects CPU queue
// - Address 3 redirects even unauthenticated ports
// - Cleared aggregation bits block egress to port
// - Zero source mask blocks ingress forwarding
// - Reserved range recognised; low nibble selects settings
module spf_filter #(
    parameter int NUM_PORTS = spf_pkg::NUM_PORTS,
    parameter int VID_W     = spf_pkg::VID_W,
    parameter int NUM_VLANS = spf_pkg::NUM_VLANS
) (
    // Clock and reset
    input  wire logic                       sys_clk_i,
    input  wire logic                       arst_n_i,
    // VLAN table command interface
    input  wire logic [VID_W-1:0]           vlan_table_index_reg_i,
    input  wire logic                       vlan_ingress_check_flag_i,
    input  wire logic [NUM_PORTS-1:0]       vlan_member_ports_i,
    input  wire logic [1:0]                 vlan_table_command_i,
    output logic                            vlan_table_busy_o,
    // Global configuration
    input  wire logic [NUM_PORTS-1:0]       port_global_ingress_check_mask_i,
    input  wire logic                       learn_filtered_suppress_i,
    input  wire logic [NUM_PORTS-1:0]       port_learn_enable_i,
    input  wire logic [NUM_PORTS*16-1:0]    reserved_addr_redirect_enable_i,
    input  wire logic [16*spf_pkg::QUEUE_W-1:0] reserved_addr_queue_select_i,
    input  wire logic [NUM_PORTS*16-1:0]    port_group_agg_masks_i,
    input  wire logic [NUM_PORTS*NUM_PORTS-1:0] port_group_src_masks_i,
    // Frame lookup request
    input  wire logic                       frm_valid_i,
    input  wire logic [4:0]                 frm_src_port_i,
    input  wire logic [VID_W-1:0]           frm_vid_i,
    input  wire logic [47:0]                frm_dmac_i,
    input  wire logic [NUM_PORTS-1:0]       frm_dest_mask_i,
    input  wire logic [spf_pkg::AGGR_W-1:0] frm_aggr_code_i,
    // Lookup result
    output logic                            res_valid_o,
    output logic [NUM_PORTS-1:0]            res_egress_mask_o,
    output logic                            res_to_cpu_o,
    output logic [spf_pkg::QUEUE_W-1:0]     res_cpu_queue_o,
    output logic                            res_learn_o,
    output logic                            res_vlan_drop_o
);
    // ------------------------------------------------------------------
    // Table command sequencer
    // ------------------------------------------------------------------
    spf_pkg::spf_cmd_state_t state;
    spf_pkg::spf_cmd_state_t next_state;
    logic                    busy;
    logic                    next_busy;
    logic                    tbl_wr;
    logic                    chk_hit;
    logic [NUM_PORTS-1:0]    members;

    always_comb begin
        next_state = state;
        next_busy  = 1'b0;
        tbl_wr     = 1'b0;
        case (state)
            spf_pkg::SPF_IDLE: begin
                if (vlan_table_command_i == spf_pkg::CMD_WRITE) begin
                    next_state = spf_pkg::SPF_WRITE;
                    next_busy  = 1'b1;
                end
            end
            spf_pkg::SPF_WRITE: begin
                tbl_wr     = 1'b1;
                next_state = spf_pkg::SPF_DONE;
                next_busy  = 1'b1;
            end
            spf_pkg::SPF_DONE: begin
                // Wait for command to return to idle so one write per issue
                if (vlan_table_command_i == spf_pkg::CMD_IDLE) begin
                    next_state = spf_pkg::SPF_IDLE;
                end else begin
                    next_busy = 1'b1;
                end
            end
            default: begin
                next_state = spf_pkg::SPF_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= spf_pkg::SPF_IDLE;
            busy  <= 1'b0;
        end else begin
            state <= next_state;
            busy  <= next_busy;
        end
    end
    assign vlan_table_busy_o = busy;

    spf_vlan_table #(
        .NUM_PORTS (NUM_PORTS),
        .VID_W     (VID_W),
        .NUM_VLANS (NUM_VLANS)
    ) u_table (
        .sys_clk_i    (sys_clk_i),
        .wr_en_i      (tbl_wr),
        .wr_idx_i     (vlan_table_index_reg_i),
        .wr_chk_i     (vlan_ingress_check_flag_i),
        .wr_members_i (vlan_member_ports_i),
        .rd_idx_i     (frm_vid_i),
        .rd_chk_o     (chk_hit),
        .rd_members_o (members)
    );

    // ------------------------------------------------------------------
    // Stage 1: hold frame fields while the table is read
    // ------------------------------------------------------------------
    logic                       s1_valid;
    logic [4:0]                 s1_src;
    logic [47:0]                s1_dmac;
    logic [NUM_PORTS-1:0]       s1_dest;
    logic [spf_pkg::AGGR_W-1:0] s1_aggr;
    logic                       next_s1_valid;

    always_comb begin
        next_s1_valid = frm_valid_i && (int'(frm_src_port_i) < NUM_PORTS);
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_valid <= 1'b0;
            s1_src   <= '0;
            s1_dmac  <= '0;
            s1_dest  <= spf_pkg::MASK_RESET;
            s1_aggr  <= '0;
        end else begin
            s1_valid <= next_s1_valid;
            s1_src   <= frm_src_port_i;
            s1_dmac  <= frm_dmac_i;
            s1_dest  <= frm_dest_mask_i;
            s1_aggr  <= frm_aggr_code_i;
        end
    end

    // ------------------------------------------------------------------
    // Stage 2: decision
    // ------------------------------------------------------------------
    function automatic logic [NUM_PORTS-1:0] pick_mask(
        input logic [NUM_PORTS*NUM_PORTS-1:0] masks,
        input logic [4:0]                     idx
    );
        pick_mask = masks[idx*NUM_PORTS +: NUM_PORTS];
    endfunction

    logic                        next_res_valid;
    logic [NUM_PORTS-1:0]        next_res_egress;
    logic                        next_res_cpu;
    logic [spf_pkg::QUEUE_W-1:0] next_res_queue;
    logic                        next_res_learn;
    logic                        next_res_drop;
    logic                        rsv;
    logic                        member;
    logic                        vlan_drop;
    logic [NUM_PORTS-1:0]        agg_mask;
    logic [NUM_PORTS-1:0]        src_mask;
    logic [3:0]                  nib;

    always_comb begin
        nib    = s1_dmac[3:0];
        rsv    = (s1_dmac[47:4] == spf_pkg::RSV_PREFIX);
        member = members[s1_src];
        // Flag with member bit 0 discards; both 1 forwards
        vlan_drop = (chk_hit || port_global_ingress_check_mask_i[s1_src])
                    && !member;
        for (int p = 0; p < NUM_PORTS; p++) begin
            agg_mask[p] = port_group_agg_masks_i[p*16 + int'(s1_aggr)];
        end
        src_mask = pick_mask(port_group_src_masks_i, s1_src);
        next_res_valid = s1_valid;
        // Redirect precedes all port-state and authentication gating
        next_res_cpu   = s1_valid && rsv
            && reserved_addr_redirect_enable_i[s1_src*16 + nib];
        next_res_queue = reserved_addr_queue_select_i[
            int'(nib)*spf_pkg::QUEUE_W +: spf_pkg::QUEUE_W];
        next_res_drop  = s1_valid && vlan_drop;
        if (!s1_valid || next_res_cpu || vlan_drop) begin
            next_res_egress = '0;
        end else begin
            next_res_egress = s1_dest & src_mask & agg_mask & members;
        end
        // No learn delay: learning follows forwarding state directly
        next_res_learn = s1_valid && port_learn_enable_i[s1_src]
            && !(learn_filtered_suppress_i && vlan_drop);
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            res_valid_o       <= 1'b0;
            res_egress_mask_o <= spf_pkg::MASK_RESET;
            res_to_cpu_o      <= 1'b0;
            res_cpu_queue_o   <= spf_pkg::QUEUE_RESET;
            res_learn_o       <= 1'b0;
            res_vlan_drop_o   <= 1'b0;
        end else begin
            res_valid_o       <= next_res_valid;
            res_egress_mask_o <= next_res_egress;
            res_to_cpu_o      <= next_res_cpu;
            res_cpu_queue_o   <= next_res_queue;
            res_learn_o       <= next_res_learn;
            res_vlan_drop_o   <= next_res_drop;
        end
    end
endmodule

// file: tb/spf_filter_assertions.sv
// Checker: port-level properties of the switch port state filter
module spf_chk #(
    parameter int NUM_PORTS = 27
) (
    // Clock and reset
    input wire logic                        sys_clk_i,
    input wire logic                        arst_n_i,
    // Configuration
    input wire logic                        learn_filtered_suppress_i,
    input wire logic [NUM_PORTS-1:0]        port_learn_enable_i,
    input wire logic [NUM_PORTS*16-1:0]     reserved_addr_redirect_enable_i,
    input wire logic [NUM_PORTS*16-1:0]     port_group_agg_masks_i,
    // Lookup request and result
    input wire logic                        frm_valid_i,
    input wire logic [4:0]                  frm_src_port_i,
    input wire logic [47:0]                 frm_dmac_i,
    input wire logic [NUM_PORTS-1:0]        frm_dest_mask_i,
    input wire logic [spf_pkg::AGGR_W-1:0]  frm_aggr_code_i,
    input wire logic                        res_valid_o,
    input wire logic [NUM_PORTS-1:0]        res_egress_mask_o,
    input wire logic                        res_to_cpu_o,
    input wire logic                        res_learn_o,
    input wire logic                        res_vlan_drop_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic                 req;
    logic                 redir;
    logic [NUM_PORTS-1:0] agg_sel;
    assign req = frm_valid_i && frm_src_port_i < NUM_PORTS;
    assign redir = frm_dmac_i[47:4] == spf_pkg::RSV_PREFIX
        && reserved_addr_redirect_enable_i[frm_src_port_i*16+frm_dmac_i[3:0]];
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            agg_sel[p] = port_group_agg_masks_i[p*16+frm_aggr_code_i];
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    chk_result_timing: assert property (
        req |-> ##2 res_valid_o) else $error("lookup gave no result");
    chk_bad_source: assert property (
        frm_valid_i && !req |-> ##2 !res_valid_o) else $error("bad port");
    chk_redirect_cpu: assert property (
        req && redir |-> ##2 res_to_cpu_o) else $error("not redirected");
    chk_agg_block: assert property (
        req |-> ##2 (res_egress_mask_o & ~$past(agg_sel, 2)) == '0)
        else $error("aggregation mask ignored");
    chk_dest_only: assert property (
        req |-> ##2 (res_egress_mask_o & ~$past(frm_dest_mask_i, 2)) == '0)
        else $error("egress outside destination");
    chk_learn_gate: assert property (
        req && !port_learn_enable_i[frm_src_port_i] |-> ##2 !res_learn_o)
        else $error("learned on disabled port");
    chk_learn_supp: assert property (
        res_vlan_drop_o && $past(learn_filtered_suppress_i) |-> !res_learn_o)
        else $error("learned filtered frame");
    chk_drop_block: assert property (
        res_vlan_drop_o || res_to_cpu_o |-> res_egress_mask_o == '0)
        else $error("dropped frame forwarded");
    cover property (res_to_cpu_o);
    cover property (res_vlan_drop_o && !res_learn_o);
    cover property (res_valid_o && res_egress_mask_o != '0);
endmodule
bind spf_filter spf_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.*);

// file: tb/spf_port_src.sv
// Partner: ingress port model issuing one-cycle lookup requests
module spf_port_src (
    input  wire logic                          sys_clk_i,
    output logic                               valid_o = 1'b0,
    output logic [4:0]                         src_o = '0,
    output logic [spf_pkg::VID_W-1:0]          vid_o = '0,
    output logic [47:0]                        dmac_o = '0,
    output logic [spf_pkg::NUM_PORTS-1:0]      dest_o = '0,
    output logic [spf_pkg::AGGR_W-1:0]         code_o = '0
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic send(input logic [4:0] s, input logic [11:0] v,
            input logic [47:0] d, input logic [26:0] m, input logic [3:0] c);
        @(negedge sys_clk_i);
        valid_o = 1'b1;
        {src_o, vid_o, dmac_o, dest_o, code_o} = {s, v, d, m, c};
        @(negedge sys_clk_i);
        valid_o = 1'b0;
        // Released fields must not look like the last frame
        {src_o, vid_o, dmac_o, dest_o, code_o} = ~{s, v, d, m, c};
    endtask
endmodule

// file: tb/spf_filter_tb_top.sv
// Testbench: directed and random lookups through the state filter
module spf_filter_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NP = spf_pkg::NUM_PORTS;
    logic             sys_clk_i, arst_n_i, vlan_ingress_check_flag_i;
    logic             learn_filtered_suppress_i, vlan_table_busy_o;
    logic             frm_valid_i, res_valid_o, res_to_cpu_o;
    logic             res_learn_o, res_vlan_drop_o;
    logic [1:0]       vlan_table_command_i;
    logic [2:0]       res_cpu_queue_o;
    logic [3:0]       frm_aggr_code_i;
    logic [4:0]       frm_src_port_i;
    logic [11:0]      vlan_table_index_reg_i, frm_vid_i;
    logic [47:0]      reserved_addr_queue_select_i, frm_dmac_i;
    logic [NP-1:0]    vlan_member_ports_i, port_learn_enable_i;
    logic [NP-1:0]    port_global_ingress_check_mask_i;
    logic [NP-1:0]    frm_dest_mask_i, res_egress_mask_o;
    logic [NP*16-1:0] reserved_addr_redirect_enable_i, port_group_agg_masks_i;
    logic [NP*NP-1:0] port_group_src_masks_i;
    logic [31:0]      lfsr = 32'h0000_0040;
    logic [31:0]      r;
    logic             ent_chk[int];
    logic [NP-1:0]    ent_mem[int];
    int               vids[4] = '{1, 20, 21, 30};
    int               error_cnt = 0;
    int               total_checks = 0;

    spf_filter dut (.*);
    spf_port_src src (.sys_clk_i(sys_clk_i), .valid_o(frm_valid_i),
        .src_o(frm_src_port_i), .vid_o(frm_vid_i), .dmac_o(frm_dmac_i),
        .dest_o(frm_dest_mask_i), .code_o(frm_aggr_code_i));

    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr_vlan(input int v, input logic c, input logic [NP-1:0] m);
        @(negedge sys_clk_i);
        vlan_table_index_reg_i = 12'(v);
        vlan_ingress_check_flag_i = c;
        vlan_member_ports_i = m;
        vlan_table_command_i = spf_pkg::CMD_WRITE;
        repeat (2) @(negedge sys_clk_i);
        chk(vlan_table_busy_o, 1);
        @(negedge sys_clk_i);
        vlan_table_command_i = spf_pkg::CMD_IDLE;
        repeat (2) @(negedge sys_clk_i);
        chk(vlan_table_busy_o, 0);
        ent_chk[v] = c;
        ent_mem[v] = m;
    endtask

    task automatic look(input logic [4:0] s, input int v, input logic [47:0] d,
            input logic [NP-1:0] m, input logic [3:0] c);
        logic          cpu;
        logic          drp;
        logic          lrn;
        logic [2:0]    q;
        logic [NP-1:0] eg;
        cpu = d[47:4] == spf_pkg::RSV_PREFIX
            && reserved_addr_redirect_enable_i[s*16+d[3:0]];
        drp = (ent_chk[v] | port_global_ingress_check_mask_i[s])
            & !ent_mem[v][s];
        lrn = port_learn_enable_i[s] & !(learn_filtered_suppress_i & drp);
        q = reserved_addr_queue_select_i[d[3:0]*3+:3];
        for (int p = 0; p < NP; p++) eg[p] = port_group_agg_masks_i[p*16+c];
        eg = eg & m & port_group_src_masks_i[s*NP+:NP] & ent_mem[v];
        src.send(s, 12'(v), d, m, c);
        // Result stands only between the second and third rising edges after the request
        @(posedge sys_clk_i);
        #1;
        chk(res_valid_o, 1);
        chk(res_to_cpu_o, cpu);
        chk(res_vlan_drop_o, drp);
        chk(res_egress_mask_o, (cpu | drp) ? '0 : eg);
        chk(res_learn_o, lrn);
        chk(res_cpu_queue_o, q);
    endtask

    initial begin
        #(40 * 20000);
        error_cnt++;
        complete_run();
    end

    initial begin
        arst_n_i = 1'b0;
        {vlan_table_command_i, vlan_table_index_reg_i} = '0;
        {vlan_ingress_check_flag_i, vlan_member_ports_i} = '0;
        {port_global_ingress_check_mask_i, reserved_addr_queue_select_i} = '0;
        reserved_addr_redirect_enable_i = '0;
        learn_filtered_suppress_i = 1'b1;
        port_learn_enable_i = '1;
        port_group_agg_masks_i = '1;
        port_group_src_masks_i = '1;
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i) arst_n_i = 1'b1;
        wr_vlan(20, 1, 27'h000_0C00);
        wr_vlan(21, 1, 27'h000_0800);
        look(10, 20, 48'h0000_0000_1234, '1, 0);
        look(10, 21, 48'h0000_0000_1234, '1, 0);
        reserved_addr_redirect_enable_i[10*16] = 1'b1;
        look(10, 21, 48'h0180_C200_0000, '1, 0);
        $display("test per-vlan state done");
        wr_vlan(1, 0, '1);
        port_group_src_masks_i[5*NP+:NP] = '0;
        for (int c = 0; c < 16; c++) port_group_agg_masks_i[5*16+c] = 1'b0;
        reserved_addr_redirect_enable_i[5*16+3] = 1'b1;
        reserved_addr_queue_select_i[9+:3] = 3'h5;
        look(5, 1, 48'h0180_C200_0003, '1, 2);
        look(5, 1, 48'h0000_0000_1234, '1, 2);
        look(6, 1, 48'h0000_0000_1234, '1, 2);
        port_group_src_masks_i[5*NP+:NP] = '1;
        for (int c = 0; c < 16; c++) port_group_agg_masks_i[5*16+c] = 1'b1;
        look(5, 1, 48'h0000_0000_1234, '1, 7);
        $display("test unauthenticated port done");
        wr_vlan(30, 0, 27'h000_0001);
        port_global_ingress_check_mask_i[7] = 1'b1;
        learn_filtered_suppress_i = 1'b0;
        look(7, 30, 48'h0000_0000_0055, '1, 1);
        src.send(5'd30, 12'd1, 48'h0, '1, 4'h0);
        @(posedge sys_clk_i);
        #1 chk(res_valid_o, 0);
        $display("test global check done");
        for (int i = 0; i < 250; i++) begin
            r = rnd();
            if (r[31:29] == 3'h0) wr_vlan(vids[r[1:0]], r[2], NP'(rnd()));
            @(negedge sys_clk_i);
            port_global_ingress_check_mask_i = NP'(rnd());
            port_learn_enable_i = NP'(rnd());
            learn_filtered_suppress_i = r[3];
            reserved_addr_queue_select_i = {reserved_addr_queue_select_i[15:0], r};
            reserved_addr_redirect_enable_i[rnd() % (NP*16)] ^= 1'b1;
            port_group_agg_masks_i[rnd() % (NP*16)] ^= 1'b1;
            port_group_src_masks_i[rnd() % (NP*NP)] ^= 1'b1;
            r = rnd();
            look(5'(r[15:0] % NP), vids[r[17:16]], r[18] ?
                {spf_pkg::RSV_PREFIX, r[22:19]} : {16'h0, rnd()},
                NP'(rnd()), r[26:23]);
        end
        $display("test random traffic done");
        complete_run();
    end
endmodule
